// [logic/pcs_core.v]
// Program counter sequencing and hardware return stack
`timescale 1ns/1ps
`default_nettype none
`include "pcs_defs.vh"
module pcs_core #(
  parameter [12:0] INT_VECTOR = `PCS_VECTOR_DEFAULT
) (
  input wire clk_in, // 40 MHz core clock
  input wire rst_n_in, // Async reset, active low
  input wire ce_in, // Clock enable, freezes all state when low
  input wire [2:0] op_in, // Sequencing operation
  input wire [10:0] operand_in, // Call/goto target operand
  input wire low_wr_in, // Instruction result goes to pc_low_byte
  input wire [7:0] low_wr_data_in, // Data written to pc_low_byte
  input wire latch_wr_in, // Write strobe for pc_high_latch
  input wire [7:0] latch_wr_data_in, // Data written to pc_high_latch
  output reg [12:0] pc_out, // Program counter
  output reg [7:0] pc_low_byte_out, // Readback of pc_low_byte
  output reg [7:0] pc_high_latch_out, // Readback of pc_high_latch
  output reg [12:0] ret_addr_out // Last popped return address
);
  // --------------------------------------------------------------
  // State
  // --------------------------------------------------------------
  reg [12:0] pc_reg;
  reg [12:0] pc_next;
  reg [7:0] latch_reg;
  reg [7:0] latch_next;
  reg [2:0] sp_reg;
  reg [2:0] sp_next;
  reg pop_pend_reg;
  reg push_en;
  reg [2:0] rd_addr;
  wire [12:0] stack_top;

  function [12:0] pcs_far_target;
    input [10:0] opnd;
    input [7:0] lat;
    begin
      pcs_far_target = {lat[4:3], opnd};
    end
  endfunction

  function [12:0] pcs_incr;
    input [12:0] v;
    begin
      pcs_incr = v + 13'h0001;
    end
  endfunction

  // --------------------------------------------------------------
  // Return stack memory
  // --------------------------------------------------------------
  pcs_stack_mem #(
    .WIDTH(`PCS_PC_WIDTH),
    .DEPTH(`PCS_STACK_DEPTH),
    .AW(`PCS_STACK_PTR_WIDTH)
  ) u_stack (
    .clk_in(clk_in),
    .rst_n_in(rst_n_in),
    .ce_in(ce_in),
    .wr_en_in(push_en),
    .wr_addr_in(sp_reg),
    .wr_data_in(pcs_incr(pc_reg)),
    .rd_addr_in(rd_addr),
    .rd_data_out(stack_top)
  );

  // --------------------------------------------------------------
  // Next-state logic
  // --------------------------------------------------------------
  // A pop reads the memory first; the counter loads from it one cycle later,
  // as the two-cycle branch of a small core would.
  always @* begin
    pc_next = pc_reg;
    latch_next = latch_reg;
    sp_next = sp_reg;
    push_en = 1'b0;
    rd_addr = sp_reg - 3'h1;
    if (latch_wr_in) begin
      latch_next = latch_wr_data_in & `PCS_LATCH_USED_MASK;
    end
    if (pop_pend_reg) begin
      pc_next = stack_top;
    end else if (low_wr_in) begin
      pc_next = {latch_reg[4:0], low_wr_data_in};
    end else begin
      case (op_in)
        `PCS_OP_STEP: begin
          pc_next = pcs_incr(pc_reg);
        end
        `PCS_OP_CALL: begin
          pc_next = pcs_far_target(operand_in, latch_reg);
          push_en = 1'b1;
          sp_next = sp_reg + 3'h1;
        end
        `PCS_OP_GOTO: begin
          pc_next = pcs_far_target(operand_in, latch_reg);
        end
        `PCS_OP_RET: begin
          sp_next = sp_reg - 3'h1;
        end
        `PCS_OP_INTR: begin
          pc_next = INT_VECTOR;
          push_en = 1'b1;
          sp_next = sp_reg + 3'h1;
        end
        default: begin
          pc_next = pc_reg;
        end
      endcase
    end
  end

  // --------------------------------------------------------------
  // Registers
  // --------------------------------------------------------------
  // Latch is written only by software; stack traffic never touches it.
  always @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      pc_reg <= `PCS_PC_RESET;
      latch_reg <= `PCS_LATCH_RESET;
      sp_reg <= 3'h0;
      pop_pend_reg <= 1'b0;
      pc_out <= `PCS_PC_RESET;
      pc_low_byte_out <= 8'h00;
      pc_high_latch_out <= `PCS_LATCH_RESET;
      ret_addr_out <= 13'h0000;
    end else if (ce_in) begin
      pc_reg <= pc_next;
      latch_reg <= latch_next;
      sp_reg <= sp_next;
      pop_pend_reg <= (op_in == `PCS_OP_RET) && !pop_pend_reg && !low_wr_in;
      pc_out <= pc_next;
      pc_low_byte_out <= pc_next[7:0];
      pc_high_latch_out <= latch_next;
      if (pop_pend_reg) begin
        ret_addr_out <= stack_top;
      end
    end
  end
endmodule // pcs_core
`default_nettype wire

// [logic/pcs_defs.vh]
// Constants for the program counter and return stack block
`ifndef PCS_DEFS_VH
`define PCS_DEFS_VH

`define PCS_PC_WIDTH 13
`define PCS_STACK_DEPTH 8
`define PCS_STACK_PTR_WIDTH 3
`define PCS_PC_RESET 13'h0000
`define PCS_LATCH_RESET 8'h00
`define PCS_LATCH_USED_MASK 8'h1F
`define PCS_VECTOR_DEFAULT 13'h0004
`define PCS_OP_NONE 3'h0
`define PCS_OP_STEP 3'h1
`define PCS_OP_CALL 3'h2
`define PCS_OP_GOTO 3'h3
`define PCS_OP_RET 3'h4
`define PCS_OP_INTR 3'h5

`endif

// [logic/pcs_stack_mem.v]
// Circular return-address memory with registered read data
`timescale 1ns/1ps
`default_nettype none
module pcs_stack_mem #(
  parameter WIDTH = 13,
  parameter DEPTH = 8,
  parameter AW = 3
) (
  input wire clk_in, // Core clock
  input wire rst_n_in, // Async reset, active low
  input wire ce_in, // Clock enable
  input wire wr_en_in, // Write strobe
  input wire [AW-1:0] wr_addr_in, // Write address
  input wire [WIDTH-1:0] wr_data_in, // Write data
  input wire [AW-1:0] rd_addr_in, // Read address
  output reg [WIDTH-1:0] rd_data_out // Registered read data
);
  reg [WIDTH-1:0] mem [0:DEPTH-1];
  integer i;

  always @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      for (i = 0; i < DEPTH; i = i + 1) begin
        mem[i] <= {WIDTH{1'b0}};
      end
      rd_data_out <= {WIDTH{1'b0}};
    end else if (ce_in) begin
      if (wr_en_in) begin
        mem[wr_addr_in] <= wr_data_in;
      end
      rd_data_out <= mem[rd_addr_in];
    end
  end
endmodule // pcs_stack_mem
`default_nettype wire

// [dv/pcs_chk_sva.sv]
// Port checker for program counter and return stack
`timescale 1ns/1ps
`default_nettype none
module pcs_chk #(parameter [12:0] INT_VECTOR = 13'h0004) (
  input wire logic clk_in, rst_n_in, ce_in, low_wr_in, latch_wr_in, // Controls
  input wire logic [2:0] op_in, // Operation
  input wire logic [10:0] operand_in, // Target
  input wire logic [7:0] low_wr_data_in, latch_wr_data_in, pc_low_byte_out, pc_high_latch_out, // Bytes
  input wire logic [12:0] pc_out, ret_addr_out // Counter and popped entry
);
  default clocking @(posedge clk_in); endclocking
  default disable iff (!rst_n_in);
  wire go = ce_in && !low_wr_in;
  low_mirror_a: assert property (pc_low_byte_out == pc_out[7:0]) else $error("low byte mismatch");
  latch_mask_a: assert property (ce_in && latch_wr_in |=> pc_high_latch_out == ($past(latch_wr_data_in) & 8'h1F))
    else $error("latch write wrong");
  low_load_a: assert property (ce_in && low_wr_in |=> {3'h0, pc_out} == {$past(pc_high_latch_out), $past(low_wr_data_in)})
    else $error("low write load wrong");
  call_load_a: assert property (go && op_in == 3'h2 |=> pc_out == {$past(pc_high_latch_out[4:3]), $past(operand_in)})
    else $error("call target wrong");
  goto_load_a: assert property (go && op_in == 3'h3 |=> pc_out == {$past(pc_high_latch_out[4:3]), $past(operand_in)})
    else $error("goto target wrong");
  step_wrap_a: assert property (go && op_in == 3'h1 |=> pc_out == $past(pc_out) + 13'h0001) else $error("step wrong");
  pop_load_a: assert property (go && op_in == 3'h4 |=> $stable(pc_out) ##1 pc_out == ret_addr_out)
    else $error("return load wrong");
  intr_vec_a: assert property (go && op_in == 3'h5 |=> pc_out == INT_VECTOR) else $error("vector wrong");
  latch_keep_a: assert property (!latch_wr_in |=> $stable(pc_high_latch_out)) else $error("latch disturbed");
endmodule // pcs_chk
bind pcs_core pcs_chk #(.INT_VECTOR(INT_VECTOR)) u_chk (.*);
`default_nettype wire

// [dv/pcs_dec_model.sv]
// Decoder stand-in that drives the sequencing ports
`timescale 1ns/1ps
`default_nettype none
module pcs_dec_model (
  input wire logic clk_in, // Core clock
  output logic [2:0] op_out, // Operation
  output logic [10:0] opnd_out, // Target
  output logic lw_out, hw_out, // Write strobes
  output logic [7:0] ld_out, hd_out // Write data
);
  initial {op_out, opnd_out, lw_out, hw_out, ld_out, hd_out} = '0;
  // Entered just after an edge; fields hold until the next call, except that a pop clears op_out, lw_out and hw_out after one cycle
  task automatic run(input logic [2:0] o, input logic [10:0] a, input logic lw, input logic [7:0] ld,
    input logic hw, input logic [7:0] hd);
    {op_out, opnd_out, lw_out, ld_out, hw_out, hd_out} = {o, a, lw, ld, hw, hd};
    @(posedge clk_in);
    #2;
    if (o == 3'h4) begin
      {op_out, lw_out, hw_out} = '0; // Swallowed slot while the pop lands
      @(posedge clk_in);
      #2;
    end
  endtask
endmodule // pcs_dec_model
`default_nettype wire

// [dv/tb_program_counter_and_stack.sv]
// Self-checking bench for program counter and return stack
`timescale 1ns/1ps
`default_nettype none
module tb_program_counter_and_stack;
  logic clk_in = 0;
  logic rst_n_in = 0;
  logic ce = 1;
  logic [2:0] op;
  logic [10:0] opnd;
  logic lw, hw;
  logic [7:0] ld, hd, pl, ph;
  logic [12:0] pc, ra;
  int err_total = 0;
  int n_tests = 0;
  always #12.5 clk_in = ~clk_in;
  pcs_dec_model u_mdl (.clk_in(clk_in), .op_out(op), .opnd_out(opnd), .lw_out(lw), .hw_out(hw), .ld_out(ld),
    .hd_out(hd));
  pcs_core u_dut (.clk_in(clk_in), .rst_n_in(rst_n_in), .ce_in(ce), .op_in(op), .operand_in(opnd),
    .low_wr_in(lw), .low_wr_data_in(ld), .latch_wr_in(hw), .latch_wr_data_in(hd), .pc_out(pc),
    .pc_low_byte_out(pl), .pc_high_latch_out(ph), .ret_addr_out(ra));
  task chk(input logic [12:0] g, input logic [12:0] e);
    n_tests++;
    if (g !== e) begin
      err_total++;
      $display("[ERR] %0t got %h exp %h", $time, g, e);
    end
  endtask
  task tally_and_finish;
    $display("checks %0d mismatches %0d", n_tests, err_total);
    if (err_total == 0 && n_tests > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  initial begin
    #50000;
    err_total++;
    tally_and_finish;
  end
  initial begin
    repeat (12) @(posedge clk_in);
    #2 rst_n_in = 1;
    chk(pc, 0);
    u_mdl.run(0, 0, 0, 0, 1, 8'hFF);
    chk(ph, 8'h1F);
    u_mdl.run(0, 0, 1, 8'hFF, 0, 0);
    chk(pc, 13'h1FFF);
    chk(pl, 8'hFF);
    u_mdl.run(1, 0, 0, 0, 0, 0);
    chk(pc, 0);
    chk(ph, 8'h1F);
    $display("low byte and latch test done");
    u_mdl.run(0, 0, 0, 0, 1, 8'h08);
    u_mdl.run(3, 11'h7FF, 0, 0, 0, 0);
    chk(pc, 13'h0FFF);
    for (int i = 0; i < 9; i++) u_mdl.run(2, (i == 0) ? 11'h123 : i, 0, 0, 0, 0);
    chk(pc, 13'h0808);
    // Ninth push lost the first entry, ninth pop reads the newest entry again
    for (int k = 0; k < 9; k++) begin
      u_mdl.run(4, 0, 0, 0, 0, 0);
      chk(pc, (k == 7) ? 13'h0924 : 13'h0808 - k % 8);
    end
    chk(ph, 8'h08);
    $display("stack test done");
    u_mdl.run(5, 0, 0, 0, 0, 0);
    chk(pc, 13'h0004);
    u_mdl.run(4, 0, 0, 0, 0, 0);
    chk(ra, 13'h0809);
    u_mdl.run(0, 0, 0, 0, 0, 0);
    // Clock enable low must freeze the counter through a step
    ce = 0;
    u_mdl.run(1, 0, 0, 0, 0, 0);
    chk(pc, 13'h0809);
    ce = 1;
    u_mdl.run(0, 0, 0, 0, 0, 0);
    #5 rst_n_in = 0;
    #5 chk(pc, 0);
    chk(ph, 0);
    $display("interrupt and reset test done");
    tally_and_finish;
  end
endmodule // tb_program_counter_and_stack
`default_nettype wire
